// File: dpc_pkg.sv
// Shared constants and types of the dosing pump mode and status controller.
// Assumes a single 100 MHz clock and a 1 ms tick derived inside the top.
package dpc_pkg;

    // ----------------------------------------------------------------
    // Clock and time base
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ     = 100_000_000;
    localparam int unsigned TICK_US    = 1000;                     // Time-base period in us
    localparam int unsigned TICK_CYC   = CLK_HZ / 1_000_000 * TICK_US;
    localparam int unsigned DEB_MS     = 20;                       // Contact debounce time
    localparam int unsigned FLASH_MS   = 500;                      // Half period of a flashing LED
    localparam int unsigned FULL_MS    = 60000;                    // Longest full-capacity run per press
    localparam int unsigned IDLE_MS    = 10000;                    // No pulse for this long means standby
    localparam int unsigned RLY_MIN_MS = 100;                      // Least relay pulse width
    localparam int unsigned MS_W       = 16;

    // ----------------------------------------------------------------
    // Rate scaling: a fraction of full flow, FRAC_ONE is 100 %
    // ----------------------------------------------------------------
    localparam int unsigned FRAC_W     = 11;
    localparam logic [10:0] FRAC_ONE   = 11'h0400;
    localparam logic [10:0] PULSE_MIN  = 11'(({21'h0, FRAC_ONE} * 125 + 99999) / 100000); // 0.125 % rounded up to 2 LSB, about 0.2 %
    localparam logic [11:0] OWE_CAP    = 12'h0800;                 // Two strokes of owed volume
    localparam int unsigned ANA_W      = 16;                       // Loop current in uA
    localparam logic [15:0] ANA_LO_UA  = 16'h1004;                 // 4.1 mA
    localparam logic [15:0] ANA_HI_UA  = 16'h4D58;                 // 19.8 mA
    localparam int unsigned ANA_MUL    = 1024 * 65536 / (19800 - 4100);

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {MODE_MANUAL, MODE_PULSE, MODE_ANALOG} dpc_mode_t;
    typedef enum logic [1:0] {R2_LOW, R2_STROKE, R2_PULSE} dpc_r2sel_t;

    typedef struct packed {
        logic       full_variant;   // 0: basic variant, 1: full variant
        logic       stop_nc;        // Stop contact normally closed
        logic       rly1_nc;        // Relay 1 normally closed
        logic       rly2_nc;        // Relay 2 normally closed
        dpc_r2sel_t rly2_sel;       // Relay 2 function
    } dpc_cfg_t;

    typedef struct packed {
        logic fault;
        logic ext_stop;
        logic tank;
        logic pulse;
        logic manual;
        logic analog;
        logic status;
    } dpc_leds_t;

endpackage : dpc_pkg

// File: dpc_sync.sv
// Pin synchroniser and debouncer for one contact input.
// Assumes tick_i is a one-cycle pulse once per millisecond.
module dpc_sync #(
    parameter int unsigned DEB_W = 5
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic tick_i,
    input  wire logic pin_i,
    output logic      deb_o,
    output logic      rise_o
);
    logic             s1_r, s2_r, s3_r;
    logic [DEB_W-1:0] cnt_r;

    // ----------------------------------------------------------------
    // Three-stage synchroniser; only s2 reads s1
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Level accepted once stable for the debounce time; rejects contact bounce
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r  <= '0;
            deb_o  <= 1'b0;
            rise_o <= 1'b0;
        end else begin
            rise_o <= 1'b0;
            if (s2_r != s3_r || s3_r == deb_o) begin
                cnt_r <= '0;
            end else if (tick_i) begin
                if (cnt_r == DEB_W'(dpc_pkg::DEB_MS - 1)) begin
                    deb_o  <= s3_r;
                    rise_o <= s3_r;
                    cnt_r  <= '0;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    end
endmodule : dpc_sync

// File: dpc_stretch.sv
// Event stretcher: holds its output for a least number of ms ticks.
// Assumes ev_i is a one-cycle pulse; a new event restarts the hold.
module dpc_stretch #(
    parameter int unsigned MS_W = 16
) (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            tick_i,
    input  wire logic            ev_i,
    input  wire logic [MS_W-1:0] hold_ms_i,
    output logic                 act_o
);
    logic [MS_W-1:0] left_r;

    // Countdown in ms; an event restarts it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            left_r <= '0;
        end else if (ev_i) begin
            left_r <= hold_ms_i;
        end else if (tick_i && left_r != '0) begin
            left_r <= left_r - 1'b1;
        end
    end

    assign act_o = (left_r != '0);
endmodule : dpc_stretch

// File: dpc_top.sv
// Mode selection, rate demand, stop handling, LEDs and relays of a
// motor-driven diaphragm dosing pump.
// Assumes one 100 MHz clock; contacts arrive raw from pins, while the
// knob, loop current, stroke and motor fault come from same-clock logic.

module dpc_top #(
    parameter int unsigned TICK_CYCLES = dpc_pkg::TICK_CYC
) (
    input  wire logic                          CLK_I,
    input  wire logic                          RST_I,
    input  wire dpc_pkg::dpc_cfg_t             CFG_I,
    input  wire logic                          MODE_KEY_I,
    input  wire logic                          FULL_KEY_I,
    input  wire logic                          EXT_STOP_I,
    input  wire logic                          PULSE_I,
    input  wire logic                          LOW_LEVEL_I,
    input  wire logic                          EMPTY_I,
    input  wire logic                          MOTOR_FAULT_I,
    input  wire logic                          STROKE_DONE_I,
    input  wire logic [dpc_pkg::FRAC_W-1:0]    KNOB_I,
    input  wire logic [dpc_pkg::ANA_W-1:0]     ANALOG_UA_I,
    output logic      [dpc_pkg::FRAC_W-1:0]    RATE_O,
    output logic                               RUN_O,
    output dpc_pkg::dpc_mode_t                 MODE_O,
    output dpc_pkg::dpc_leds_t                 LEDS_O,
    output logic                               RELAY1_O,
    output logic                               RELAY2_O
);
    localparam logic [10:0] ONE = dpc_pkg::FRAC_ONE;

    logic [16:0]            tick_cnt_r;
    logic                   tick;
    logic [dpc_pkg::MS_W-1:0] flash_cnt_r;
    logic                   flash_r;
    logic                   mode_db, mode_rise, full_db, stop_db, pulse_db, pulse_rise;
    logic                   low_db, empty_db;
    dpc_pkg::dpc_mode_t     mode_r;
    logic [dpc_pkg::MS_W-1:0] full_cnt_r;
    logic                   full_act;
    logic [10:0]            knob;
    logic [10:0]            pulse_vol;
    logic [11:0]            owed_r;
    logic [11:0]            owed_nxt;
    logic [dpc_pkg::MS_W-1:0] idle_cnt_r;
    logic                   pulse_idle;
    logic [15:0]            ana_diff;
    logic [31:0]            ana_prod;
    logic [10:0]            ana_frac;
    logic [21:0]            ana_rate;
    logic                   ext_act, stop_any, ana_low;
    logic [10:0]            rate_nxt;
    logic                   standby;
    logic                   stroke_ev, pulse_ev;
    logic                   r2_act;

    // ----------------------------------------------------------------
    // Millisecond time base and LED flash clock
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            tick_cnt_r <= '0;
        end else if (tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
        end
    end
    assign tick = (tick_cnt_r == 17'(TICK_CYCLES - 1));

    // Flash phase toggles every half period
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            flash_cnt_r <= '0;
            flash_r     <= 1'b0;
        end else if (tick) begin
            if (flash_cnt_r == 16'(dpc_pkg::FLASH_MS - 1)) begin
                flash_cnt_r <= '0;
                flash_r     <= ~flash_r;
            end else begin
                flash_cnt_r <= flash_cnt_r + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Contact inputs
    // ----------------------------------------------------------------
    dpc_sync u_mode  (.clk_i(CLK_I), .rst_i(RST_I), .tick_i(tick), .pin_i(MODE_KEY_I),
                      .deb_o(mode_db), .rise_o(mode_rise));
    dpc_sync u_full  (.clk_i(CLK_I), .rst_i(RST_I), .tick_i(tick), .pin_i(FULL_KEY_I),
                      .deb_o(full_db), .rise_o());
    dpc_sync u_stop  (.clk_i(CLK_I), .rst_i(RST_I), .tick_i(tick), .pin_i(EXT_STOP_I),
                      .deb_o(stop_db), .rise_o());
    dpc_sync u_pulse (.clk_i(CLK_I), .rst_i(RST_I), .tick_i(tick), .pin_i(PULSE_I),
                      .deb_o(pulse_db), .rise_o(pulse_rise));
    dpc_sync u_low   (.clk_i(CLK_I), .rst_i(RST_I), .tick_i(tick), .pin_i(LOW_LEVEL_I),
                      .deb_o(low_db), .rise_o());
    dpc_sync u_empty (.clk_i(CLK_I), .rst_i(RST_I), .tick_i(tick), .pin_i(EMPTY_I),
                      .deb_o(empty_db), .rise_o());

    // ----------------------------------------------------------------
    // Operation mode
    // ----------------------------------------------------------------
    // Basic variant has no mode key and stays in manual
    always_ff @(posedge CLK_I) begin
        if (RST_I || !CFG_I.full_variant) begin
            mode_r <= dpc_pkg::MODE_MANUAL;
        end else if (mode_rise) begin
            unique case (mode_r)
                dpc_pkg::MODE_MANUAL: mode_r <= dpc_pkg::MODE_PULSE;
                dpc_pkg::MODE_PULSE:  mode_r <= dpc_pkg::MODE_ANALOG;
                dpc_pkg::MODE_ANALOG: mode_r <= dpc_pkg::MODE_MANUAL;
                default:              mode_r <= dpc_pkg::MODE_MANUAL;
            endcase
        end
    end
    assign MODE_O = mode_r;

    // ----------------------------------------------------------------
    // Full-capacity key
    // ----------------------------------------------------------------
    // Time is bounded so a stuck key cannot overdose indefinitely
    always_ff @(posedge CLK_I) begin
        if (RST_I || !full_db) begin
            full_cnt_r <= '0;
        end else if (tick && full_act) begin
            full_cnt_r <= full_cnt_r + 1'b1;
        end
    end
    assign full_act = full_db && (full_cnt_r < 16'(dpc_pkg::FULL_MS));

    // ----------------------------------------------------------------
    // Pulse mode: owed volume accumulator
    // ----------------------------------------------------------------
    assign knob      = (KNOB_I > ONE) ? ONE : KNOB_I;
    assign pulse_vol = (knob < dpc_pkg::PULSE_MIN) ? dpc_pkg::PULSE_MIN : knob;

    // Each pulse adds its volume, a stroke pays one stroke back when a whole stroke is owed
    always_comb begin
        owed_nxt = owed_r;
        if (STROKE_DONE_I && owed_nxt >= {1'b0, ONE}) begin
            owed_nxt = owed_nxt - {1'b0, ONE};
        end
        if (pulse_rise) begin
            owed_nxt = owed_nxt + {1'b0, pulse_vol};
        end
        if (owed_nxt > dpc_pkg::OWE_CAP) begin
            owed_nxt = dpc_pkg::OWE_CAP;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I || mode_r != dpc_pkg::MODE_PULSE) begin
            owed_r <= '0;
        end else begin
            owed_r <= owed_nxt;
        end
    end

    // Pulse silence detector
    always_ff @(posedge CLK_I) begin
        if (RST_I || pulse_rise) begin
            idle_cnt_r <= '0;
        end else if (tick && !pulse_idle) begin
            idle_cnt_r <= idle_cnt_r + 1'b1;
        end
    end
    assign pulse_idle = (idle_cnt_r == 16'(dpc_pkg::IDLE_MS));

    // ----------------------------------------------------------------
    // Analog mode: linear map 4.1..19.8 mA onto 0..knob
    // ----------------------------------------------------------------
    // Multiply by a reciprocal to avoid a divider; error below one LSB
    assign ana_low  = (ANALOG_UA_I <= dpc_pkg::ANA_LO_UA);
    assign ana_diff = ana_low ? 16'h0000 : ANALOG_UA_I - dpc_pkg::ANA_LO_UA;
    assign ana_prod = 32'(ana_diff) * 32'(dpc_pkg::ANA_MUL);
    assign ana_frac = (ANALOG_UA_I >= dpc_pkg::ANA_HI_UA || ana_prod[31:16] > 16'(ONE))
                      ? ONE : ana_prod[26:16];
    assign ana_rate = 22'(knob) * 22'(ana_frac);

    // ----------------------------------------------------------------
    // Stop conditions and rate demand
    // ----------------------------------------------------------------
    assign ext_act  = CFG_I.full_variant && (stop_db ^ CFG_I.stop_nc);
    assign stop_any = ext_act || empty_db || MOTOR_FAULT_I;

    always_comb begin
        rate_nxt = '0;
        if (stop_any) begin
            rate_nxt = '0;
        end else if (full_act) begin
            rate_nxt = ONE;
        end else begin
            unique case (mode_r)
                dpc_pkg::MODE_MANUAL: rate_nxt = knob;
                dpc_pkg::MODE_PULSE:  rate_nxt = (owed_r >= {1'b0, ONE}) ? ONE : 11'h000;
                dpc_pkg::MODE_ANALOG: rate_nxt = ana_rate[20:10];
                default:              rate_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            RATE_O <= '0;
            RUN_O  <= 1'b0;
        end else begin
            RATE_O <= rate_nxt;
            RUN_O  <= (rate_nxt != '0);
        end
    end

    // ----------------------------------------------------------------
    // LEDs
    // ----------------------------------------------------------------
    // Standby shows as a flashing mode LED; empty tank and motor fault do not by themselves make it flash
    assign standby = !full_act && (ext_act ||
                     (mode_r == dpc_pkg::MODE_MANUAL && knob == '0) ||
                     (mode_r == dpc_pkg::MODE_PULSE && pulse_idle && owed_r < {1'b0, ONE}) ||
                     (mode_r == dpc_pkg::MODE_ANALOG && (ana_low || knob == '0)));

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            LEDS_O <= '0;
        end else begin
            LEDS_O.manual   <= CFG_I.full_variant && mode_r == dpc_pkg::MODE_MANUAL &&
                               (!standby || flash_r);
            LEDS_O.pulse    <= CFG_I.full_variant && mode_r == dpc_pkg::MODE_PULSE &&
                               (!standby || flash_r);
            LEDS_O.analog   <= CFG_I.full_variant && mode_r == dpc_pkg::MODE_ANALOG &&
                               (!standby || flash_r);
            LEDS_O.status   <= !CFG_I.full_variant && !stop_any &&
                               (!standby || flash_r);
            LEDS_O.fault    <= MOTOR_FAULT_I && flash_r;
            LEDS_O.ext_stop <= ext_act;
            LEDS_O.tank     <= CFG_I.full_variant &&
                               (empty_db || (low_db && flash_r));
        end
    end

    // ----------------------------------------------------------------
    // Relays
    // ----------------------------------------------------------------
    assign pulse_ev  = pulse_rise;
    assign stroke_ev = STROKE_DONE_I;

    // Short events stretched so the relay can actually pull in
    dpc_stretch #(.MS_W(dpc_pkg::MS_W)) u_r2_stretch (
        .clk_i    (CLK_I),
        .rst_i    (RST_I),
        .tick_i   (tick),
        .ev_i     ((CFG_I.rly2_sel == dpc_pkg::R2_STROKE) ? stroke_ev : pulse_ev),
        .hold_ms_i(16'(dpc_pkg::RLY_MIN_MS)),
        .act_o    (r2_act)
    );

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            RELAY1_O <= 1'b0;
            RELAY2_O <= 1'b0;
        end else begin
            RELAY1_O <= (empty_db || MOTOR_FAULT_I) ^ CFG_I.rly1_nc;
            unique case (CFG_I.rly2_sel)
                dpc_pkg::R2_STROKE,
                dpc_pkg::R2_PULSE: RELAY2_O <= r2_act ^ CFG_I.rly2_nc;
                default:           RELAY2_O <= low_db ^ CFG_I.rly2_nc;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_mode_onehot: assert property (@(posedge CLK_I) disable iff (RST_I)
        $countones({LEDS_O.manual, LEDS_O.pulse, LEDS_O.analog}) <= 1)
        else $error("more than one mode LED lit");

    chk_mode_advance: assert property (@(posedge CLK_I) disable iff (RST_I)
        mode_rise && CFG_I.full_variant |=> mode_r != $past(mode_r))
        else $error("mode key did not change mode");

    chk_mode_order: assert property (@(posedge CLK_I) disable iff (RST_I)
        mode_rise && CFG_I.full_variant && mode_r == dpc_pkg::MODE_PULSE
        |=> mode_r == dpc_pkg::MODE_ANALOG)
        else $error("mode order broken");

    chk_full_rate: assert property (@(posedge CLK_I) disable iff (RST_I)
        full_act && !stop_any |=> RATE_O == ONE && RUN_O)
        else $error("full key did not give full rate");

    chk_manual_rate: assert property (@(posedge CLK_I) disable iff (RST_I)
        mode_r == dpc_pkg::MODE_MANUAL && !full_act && !stop_any |=> RATE_O == $past(knob))
        else $error("manual rate differs from knob");

    chk_surplus_cap: assert property (@(posedge CLK_I) disable iff (RST_I)
        owed_r <= dpc_pkg::OWE_CAP)
        else $error("surplus pulses stored");

    chk_analog_low: assert property (@(posedge CLK_I) disable iff (RST_I)
        mode_r == dpc_pkg::MODE_ANALOG && ana_low && !full_act && !stop_any |=> RATE_O == '0)
        else $error("analog below threshold still doses");

    chk_stop_rate: assert property (@(posedge CLK_I) disable iff (RST_I)
        stop_any |=> !RUN_O && RATE_O == '0)
        else $error("pump runs while stopped");

    chk_ext_led: assert property (@(posedge CLK_I) disable iff (RST_I)
        ext_act ##1 ext_act |-> LEDS_O.ext_stop)
        else $error("external stop LED not steady");

    chk_alarm_relay: assert property (@(posedge CLK_I) disable iff (RST_I)
        MOTOR_FAULT_I && !CFG_I.rly1_nc ##1 !CFG_I.rly1_nc |-> RELAY1_O)
        else $error("alarm relay not active on fault");
endmodule : dpc_top

// File: dpc_field.sv
// Far-side model: keys, stop contact, pulse meter and level switches.
// Assumes the bench sets the wanted contact levels at clock edges.
module dpc_field (
    input  wire logic       clk_i,
    input  wire logic [5:0] want_i,
    output logic      [5:0] pins_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Contact chatter
    // ------------------------------------------------------------
    logic [5:0] prev_r = '0;
    logic [5:0] chg_r  = '0;
    logic [2:0] cnt_r  = '0;
    // Only the contacts that moved chatter, and far shorter than any debounce
    always_ff @(posedge clk_i) begin
        prev_r <= want_i;
        chg_r  <= (want_i != prev_r) ? (want_i ^ prev_r) : chg_r;
        cnt_r  <= (want_i != prev_r) ? 3'h5 : cnt_r - {2'h0, cnt_r != 3'h0};
        pins_o <= cnt_r[0] ? (want_i ^ chg_r) : want_i;
    end
endmodule : dpc_field

// File: tb.sv
// Self-checking bench of the dosing pump controller, 10-cycle ms tick.
// Assumes dpc_field drives the contact pins; all else is driven here.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Signals, model state and instances
    // ------------------------------------------------------------
    logic               clk = 0;
    logic               rst = 1;
    dpc_pkg::dpc_cfg_t  cfg = {4'h8, dpc_pkg::R2_PULSE};
    logic [5:0]         want = '0;
    logic [5:0]         pins;
    logic               fault = 0;
    logic               stroke = 0;
    logic [10:0]        knob = '0;
    logic [15:0]        ua = 16'h2EE0;
    logic [10:0]        rate;
    logic               run;
    logic               rl1;
    logic               rl2;
    dpc_pkg::dpc_mode_t mode;
    dpc_pkg::dpc_leds_t leds;
    int                 mismatches = 0;
    int                 n_checks = 0;
    logic [15:0]        lfsr = 16'hCEBA;
    int                 uas[6] = '{4000, 4100, 4101, 12000, 19800, 20000};
    // Free-running 100 MHz clock
    always #5 clk = ~clk;
    dpc_field FLD (.clk_i(clk), .want_i(want), .pins_o(pins));
    dpc_top #(.TICK_CYCLES(10)) DUT (.CLK_I(clk), .RST_I(rst), .CFG_I(cfg), .MODE_KEY_I(pins[5]),
        .FULL_KEY_I(pins[4]), .EXT_STOP_I(pins[3]), .PULSE_I(pins[2]), .LOW_LEVEL_I(pins[1]),
        .EMPTY_I(pins[0]), .MOTOR_FAULT_I(fault), .STROKE_DONE_I(stroke), .KNOB_I(knob),
        .ANALOG_UA_I(ua), .RATE_O(rate), .RUN_O(run), .MODE_O(mode), .LEDS_O(leds),
        .RELAY1_O(rl1), .RELAY2_O(rl2));
    // ------------------------------------------------------------
    // Helpers: stimulus, reference model, comparison, verdict
    // ------------------------------------------------------------
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction : rnd
    // Reference rate with integers; knob clamps at full scale
    function automatic int exp_rate(input int m, input int k, input int u);
        int f;
        k = (k > 1024) ? 1024 : k;
        f = (u <= 4100) ? 0 : (u >= 19800) ? 1024 : ((u - 4100) * 4274) >>> 16;
        return (m == 0) ? k : (k * f) >>> 10;
    endfunction : exp_rate
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Debounce needs 3 sync cycles plus 20 ticks; 260 cycles covers it
    task automatic pin(input int b, input logic v);
        @(posedge clk) want[b] <= v;
        cyc(260);
    endtask : pin
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    // Hang guard, well beyond the roughly 12600 cycles the tests need
    initial begin
        #400_000;
        mismatches++;
        wrap_up();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [15:0] v;
        logic        f0;
        cyc(5);
        @(posedge clk) rst <= 1'b0;
        cyc(2);
        chk(mode, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            v = rnd() & 16'h07FF;
            @(posedge clk) knob <= v[10:0];
            cyc(2);
            chk(rate, 16'(exp_rate(0, v, 0)));
        end
        @(posedge clk) knob <= '0;
        cyc(2);
        chk(run, 16'h0000);
        pin(4, 1'b1);
        chk(rate, 16'h0400);
        pin(4, 1'b0);
        @(posedge clk) knob <= 11'h0400;
        // Each press advances one mode; only that mode's LED lights
        for (int i = 1; i <= 3; i++) begin
            pin(5, 1'b1);
            pin(5, 1'b0);
            chk(mode, 16'(i % 3));
            chk({leds.pulse, leds.manual, leds.analog}, (i % 3 == 1) ? 3'h4 : (i % 3 == 2) ? 3'h1 : 3'h2);
        end
        pin(5, 1'b1);
        pin(5, 1'b0);
        pin(2, 1'b1);
        chk(rate, 16'h0400);
        chk(rl2, 16'h0001);
        pin(2, 1'b0);
        for (int i = 0; i < 2; i++) begin
            pin(2, 1'b1);
            pin(2, 1'b0);
        end
        // Owed volume caps at two strokes, so two strokes empty it
        for (int i = 0; i < 2; i++) begin
            @(posedge clk) stroke <= 1'b1;
            @(posedge clk) stroke <= 1'b0;
            cyc(2);
            chk(rate, (i == 0) ? 16'h0400 : 16'h0000);
        end
        pin(5, 1'b1);
        pin(5, 1'b0);
        foreach (uas[i]) begin
            v = rnd() & 16'h07FF;
            @(posedge clk) begin
                knob <= v[10:0];
                ua   <= 16'(uas[i]);
            end
            cyc(2);
            chk(rate, 16'(exp_rate(2, v, uas[i])));
        end
        pin(3, 1'b1);
        chk(rate, 16'h0000);
        chk(leds.ext_stop, 16'h0001);
        @(posedge clk) cfg.stop_nc <= 1'b1;
        cyc(260);
        chk(run, 16'(exp_rate(2, v, uas[5]) != 0));
        pin(3, 1'b0);
        @(posedge clk) cfg.stop_nc <= 1'b0;
        pin(0, 1'b1);
        chk({leds.tank, rl1, run}, 16'h0006);
        @(posedge clk) cfg.rly1_nc <= 1'b1;
        cyc(2);
        chk(rl1, 16'h0000);
        pin(0, 1'b0);
        // Low level: relay 2 in its default function, pump keeps dosing
        @(posedge clk) cfg.rly2_sel <= dpc_pkg::R2_LOW;
        pin(1, 1'b1);
        chk(rl2, 16'h0001);
        chk(run, 16'(exp_rate(2, v, uas[5]) != 0));
        @(posedge clk) cfg.rly2_nc <= 1'b1;
        cyc(2);
        chk(rl2, 16'h0000);
        pin(1, 1'b0);
        // Stroke echo is held for the least relay time, then drops
        @(posedge clk) begin
            cfg.rly2_nc  <= 1'b0;
            cfg.rly2_sel <= dpc_pkg::R2_STROKE;
        end
        @(posedge clk) stroke <= 1'b1;
        @(posedge clk) stroke <= 1'b0;
        cyc(3);
        chk(rl2, 16'h0001);
        cyc(1020);
        chk(rl2, 16'h0000);
        @(posedge clk) fault <= 1'b1;
        cyc(3);
        chk({rl1, run}, 16'h0000);
        @(posedge clk) cfg.rly1_nc <= 1'b0;
        cyc(2);
        chk(rl1, 16'h0001);
        // Fault LED flashes: one half period later it shows the other phase
        f0 = leds.fault;
        cyc(5000);
        chk(leds.fault, 16'(!f0));
        // Basic variant: manual only, single status LED steady while running
        @(posedge clk) begin
            cfg.full_variant <= 1'b0;
            fault            <= 1'b0;
            knob             <= 11'h0200;
        end
        cyc(3);
        chk(mode, 16'h0000);
        chk({leds.status, leds.manual, leds.pulse, leds.analog}, 16'h0008);
        chk(rate, 16'h0200);
        wrap_up();
    end
endmodule : tb
